// ### core/adc_sequencer_regs.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module adc_sequencer_regs (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [7:1] trigger_sources_i,
  input wire logic irq_vector_ack_i,
  input wire logic global_irq_enable_i,
  input wire logic [10:0] ana_value_i,
  output logic ana_enable_o,
  output logic ana_sample_o,
  output logic [1:0] ana_reference_o,
  output logic [4:0] ana_channel_o,
  output logic conversion_irq_o
);
  // Control/status storage
  logic converter_enable_r;
  logic auto_trigger_enable_r;
  logic conversion_done_flag_r;
  logic conversion_irq_enable_r;
  logic [2:0] converter_clock_divider_r;
  logic [7:0] channel_reference_select_r;
  logic [2:0] trigger_source_select_r;
  logic [9:0] result_r;
  logic result_lock_r;
  logic first_pending_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  adc_seq_pkg::conv_state_t state_r;
  logic [4:0] cycles_left_r;
  logic [6:0] prescale_cnt_r;
  logic [1:0] conv_reference_r;
  logic [4:0] conv_channel_r;
  logic ana_sample_r;
  logic irq_r;
  logic [10:0] ana_meta_r;
  logic [10:0] ana_sync_r;
  logic trig_prev_r;

  // Bus decode
  logic [9:0] word_idx;
  logic access_done;
  logic wr_en;
  logic rd_en;
  logic hit_low;
  logic hit_high;
  logic hit_csr;
  logic hit_mux;
  logic hit_ctlb;
  logic mapped;
  assign word_idx = paddr_i[11:2];
  assign access_done = psel_i & penable_i & pready_r;
  assign wr_en = access_done & pwrite_i;
  assign rd_en = access_done & ~pwrite_i;
  assign hit_low = (word_idx == {2'h0, `IDX_RESULT_LOW}) && (paddr_i[1:0] == 2'h0);
  assign hit_high = (word_idx == {2'h0, `IDX_RESULT_HIGH}) && (paddr_i[1:0] == 2'h0);
  assign hit_csr = (word_idx == {2'h0, `IDX_CONTROL_STATUS}) && (paddr_i[1:0] == 2'h0);
  assign hit_mux = (word_idx == {2'h0, `IDX_CHANNEL_REF}) && (paddr_i[1:0] == 2'h0);
  assign hit_ctlb = (word_idx == {2'h0, `IDX_CONTROL_B}) && (paddr_i[1:0] == 2'h0);
  assign mapped = hit_low | hit_high | hit_csr | hit_mux | hit_ctlb;

  // Control write events
  logic csr_wr;
  logic start_req_sw;
  logic busy;
  assign csr_wr = wr_en & hit_csr;
  assign busy = (state_r == adc_seq_pkg::CONV_RUN);
  // Writing zero to the start bit does nothing; start needs enable too
  assign start_req_sw = csr_wr & pwdata_i[`CSR_START] & pwdata_i[`CSR_EN];

  // Prescaler: tick when the low bits of the counter wrap
  logic [6:0] div_mask;
  logic conv_tick;
  always_comb begin
    unique case (converter_clock_divider_r)
      3'h0, 3'h1: div_mask = 7'h01;
      3'h2: div_mask = 7'h03;
      3'h3: div_mask = 7'h07;
      3'h4: div_mask = 7'h0f;
      3'h5: div_mask = 7'h1f;
      3'h6: div_mask = 7'h3f;
      3'h7: div_mask = 7'h7f;
    endcase
  end
  assign conv_tick = ((prescale_cnt_r & div_mask) == div_mask);

  // Free-running prescaler, held at zero while the converter is off
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prescale_cnt_r <= 7'h00;
    end else if (!converter_enable_r) begin
      prescale_cnt_r <= 7'h00;
    end else begin
      prescale_cnt_r <= prescale_cnt_r + 7'h01;
    end
  end

  // Trigger selection; source zero feeds a constant so no edge appears
  logic trig_sel;
  logic trig_edge;
  assign trig_sel = (trigger_source_select_r == 3'h0) ? 1'b0 :
                    trigger_sources_i[trigger_source_select_r];
  assign trig_edge = trig_sel & ~trig_prev_r;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trig_prev_r <= 1'b0;
    end else begin
      trig_prev_r <= trig_sel;
    end
  end

  // Analog value comes from another domain: two flops first
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ana_meta_r <= 11'h000;
      ana_sync_r <= 11'h000;
    end else begin
      ana_meta_r <= ana_value_i;
      ana_sync_r <= ana_meta_r;
    end
  end

  // Channel kind decode of the latched channel
  adc_seq_pkg::channel_kind_t conv_kind;
  always_comb begin
    if (conv_channel_r == 5'h1e) begin
      conv_kind = adc_seq_pkg::CH_BANDGAP;
    end else if (conv_channel_r == 5'h1f) begin
      conv_kind = adc_seq_pkg::CH_GROUND;
    end else if (conv_channel_r[4]) begin
      conv_kind = adc_seq_pkg::CH_DIFF;
    end else begin
      conv_kind = adc_seq_pkg::CH_SINGLE;
    end
  end

  // Code forming: saturate the front-end value to the legal range
  logic [9:0] conv_code;
  always_comb begin
    conv_code = 10'h000;
    unique case (conv_kind)
      adc_seq_pkg::CH_DIFF: begin
        if (!ana_sync_r[10] && (ana_sync_r[9] != 1'b0)) begin
          conv_code = `DIFF_MAX;
        end else if (ana_sync_r[10] && (ana_sync_r[9] != 1'b1)) begin
          conv_code = `DIFF_MIN;
        end else begin
          conv_code = ana_sync_r[9:0];
        end
      end
      adc_seq_pkg::CH_GROUND: conv_code = 10'h000;
      default: begin
        conv_code = ana_sync_r[10] ? `SE_MAX : ana_sync_r[9:0];
      end
    endcase
  end

  // Conversion sequencing
  logic conv_last;
  logic conv_finish;
  logic free_running;
  logic start_any;
  assign conv_last = busy & conv_tick & (cycles_left_r == 5'd1);
  assign conv_finish = conv_last & converter_enable_r;
  assign free_running = auto_trigger_enable_r & (trigger_source_select_r == 3'h0);
  assign start_any = start_req_sw | (converter_enable_r & auto_trigger_enable_r & trig_edge)
                     | (conv_finish & free_running);

  // Conversion state; an enable write of zero aborts at once
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= adc_seq_pkg::CONV_IDLE;
      cycles_left_r <= 5'd0;
      conv_reference_r <= 2'h0;
      conv_channel_r <= 5'h00;
    end else if (csr_wr && !pwdata_i[`CSR_EN]) begin
      state_r <= adc_seq_pkg::CONV_IDLE;
      cycles_left_r <= 5'd0;
    end else if (start_any && (!busy || conv_finish)) begin
      state_r <= adc_seq_pkg::CONV_RUN;
      cycles_left_r <= first_pending_r || (csr_wr && !converter_enable_r) ?
                       `FIRST_CONV_CYCLES : `NORMAL_CONV_CYCLES;
      conv_reference_r <= channel_reference_select_r[7:6];
      conv_channel_r <= channel_reference_select_r[4:0];
    end else if (conv_finish) begin
      state_r <= adc_seq_pkg::CONV_IDLE;
      cycles_left_r <= 5'd0;
    end else if (busy && conv_tick) begin
      cycles_left_r <= cycles_left_r - 5'd1;
    end
  end

  // First conversion after enabling runs the longer initialisation
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      first_pending_r <= 1'b0;
    end else if (csr_wr && pwdata_i[`CSR_EN] && !converter_enable_r) begin
      first_pending_r <= !start_req_sw;
    end else if (csr_wr && !pwdata_i[`CSR_EN]) begin
      first_pending_r <= 1'b0;
    end else if (start_any && !busy) begin
      first_pending_r <= 1'b0;
    end
  end

  // Control/status register; enable, auto-trigger, interrupt enable and divider written as given
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      converter_enable_r <= 1'(`CSR_RESET >> `CSR_EN);
      auto_trigger_enable_r <= 1'b0;
      conversion_irq_enable_r <= 1'b0;
      converter_clock_divider_r <= 3'h0;
    end else if (csr_wr) begin
      converter_enable_r <= pwdata_i[`CSR_EN];
      auto_trigger_enable_r <= pwdata_i[`CSR_ATE];
      conversion_irq_enable_r <= pwdata_i[`CSR_IE];
      converter_clock_divider_r <= pwdata_i[2:0];
    end
  end

  // Done flag: a completion in the clearing cycle still sets it
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      conversion_done_flag_r <= 1'b0;
    end else if (conv_finish) begin
      conversion_done_flag_r <= 1'b1;
    end else if (irq_vector_ack_i || (csr_wr && pwdata_i[`CSR_FLAG])) begin
      conversion_done_flag_r <= 1'b0;
    end
  end

  // Interrupt request follows flag and both enables
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= conversion_done_flag_r & conversion_irq_enable_r & global_irq_enable_i;
    end
  end

  // Result holding register; a locked pair discards the new result
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_r <= 10'h000;
    end else if (conv_finish && !result_lock_r) begin
      result_r <= conv_code;
    end
  end

  // Low byte read locks, high byte read releases
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_lock_r <= 1'b0;
    end else if (rd_en && hit_high) begin
      result_lock_r <= 1'b0;
    end else if (rd_en && hit_low) begin
      result_lock_r <= 1'b1;
    end
  end

  // Channel/reference and trigger source registers
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      channel_reference_select_r <= `MUX_RESET;
      trigger_source_select_r <= 3'h0;
    end else begin
      if (wr_en && hit_mux) begin
        channel_reference_select_r <= pwdata_i[7:0];
      end
      if (wr_en && hit_ctlb) begin
        trigger_source_select_r <= pwdata_i[2:0];
      end
    end
  end

  // Presentation follows the live justify bit
  logic [7:0] res_low;
  logic [7:0] res_high;
  always_comb begin
    if (channel_reference_select_r[`MUX_LEFT]) begin
      res_high = result_r[9:2];
      res_low = {result_r[1:0], 6'h00};
    end else begin
      res_high = {6'h00, result_r[9:8]};
      res_low = result_r[7:0];
    end
  end

  // Read mux
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_low) begin
      rd_byte = res_low;
    end else if (hit_high) begin
      rd_byte = res_high;
    end else if (hit_csr) begin
      rd_byte = {converter_enable_r, busy, auto_trigger_enable_r, conversion_done_flag_r,
                 conversion_irq_enable_r, converter_clock_divider_r};
    end else if (hit_mux) begin
      rd_byte = channel_reference_select_r;
    end else if (hit_ctlb) begin
      rd_byte = {5'h00, trigger_source_select_r};
    end
  end

  // APB slave: one wait cycle, data captured in the first access cycle
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= psel_i & penable_i & ~pready_r;
      if (psel_i && penable_i && !pready_r) begin
        prdata_r <= {24'h00_0000, rd_byte};
        pslverr_r <= ~mapped;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // Front-end controls from flops; sample strobe marks conversion start
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ana_sample_r <= 1'b0;
    end else begin
      ana_sample_r <= start_any & (!busy | conv_finish) & ~(csr_wr & ~pwdata_i[`CSR_EN]);
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign ana_enable_o = converter_enable_r;
  assign ana_sample_o = ana_sample_r;
  assign ana_reference_o = conv_reference_r;
  assign ana_channel_o = conv_channel_r;
  assign conversion_irq_o = irq_r;
endmodule // adc_sequencer_regs

// ### pkg/adc_seq_defs.svh
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_RESULT_LOW 8'h78
`define IDX_RESULT_HIGH 8'h79
`define IDX_CONTROL_STATUS 8'h7a
`define IDX_CHANNEL_REF 8'h7b
`define IDX_CONTROL_B 8'h7c
`define CSR_RESET 8'h00
`define MUX_RESET 8'h00
`define CTLB_RESET 8'h00
// Control/status fields
`define CSR_EN 7
`define CSR_START 6
`define CSR_ATE 5
`define CSR_FLAG 4
`define CSR_IE 3
// Channel/reference fields
`define MUX_LEFT 5
// Conversion lengths in converter clock cycles
`define FIRST_CONV_CYCLES 5'd25
`define NORMAL_CONV_CYCLES 5'd13
// Saturation limits
`define SE_MAX 10'h3ff
`define DIFF_MAX 10'h1ff
`define DIFF_MIN 10'h200
`endif

// ### pkg/adc_seq_pkg.sv
package adc_seq_pkg;
  typedef enum logic [1:0] {
    REF_EXT_PIN = 2'h0,
    REF_SUPPLY = 2'h1,
    REF_RESERVED = 2'h2,
    REF_BANDGAP = 2'h3
  } reference_t;
  typedef enum logic [1:0] {
    CH_SINGLE,
    CH_DIFF,
    CH_BANDGAP,
    CH_GROUND
  } channel_kind_t;
  typedef enum logic {
    CONV_IDLE,
    CONV_RUN
  } conv_state_t;
endpackage

// ### verification/adc_sequencer_regs_properties.sv
`timescale 1ns/1ps
module adc_sequencer_regs_checker (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic global_irq_enable_i,
  input wire logic ana_enable_o,
  input wire logic ana_sample_o,
  input wire logic [1:0] ana_reference_o,
  input wire logic [4:0] ana_channel_o,
  input wire logic conversion_irq_o
);
  logic wr_ctl;
  // Control write lands at the edge where the answer is sampled
  assign wr_ctl = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 12'h1e8;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  property p_en_on; wr_ctl && pwdata_i[7] |=> ana_enable_o; endproperty
  a_en_on: assert property (p_en_on) else $error("enable write ignored");
  property p_en_off; wr_ctl && !pwdata_i[7] |=> !ana_enable_o; endproperty
  a_en_off: assert property (p_en_off) else $error("disable write ignored");
  property p_smp_en; ana_sample_o |-> ana_enable_o || $past(ana_enable_o); endproperty
  a_smp_en: assert property (p_smp_en) else $error("sample while off");
  property p_smp_pulse; ana_sample_o |=> !ana_sample_o; endproperty
  a_smp_pulse: assert property (p_smp_pulse) else $error("sample not a pulse");
  // Settings may only move when a conversion begins
  property p_hold;
    $changed(ana_channel_o) || $changed(ana_reference_o) |-> ##[0:1] ana_sample_o;
  endproperty
  a_hold: assert property (p_hold) else $error("settings moved mid conversion");
  property p_irq; conversion_irq_o |-> $past(global_irq_enable_i); endproperty
  a_irq: assert property (p_irq) else $error("irq without global enable");
  property p_rdy; pready_o |=> !pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("ready longer than one cycle");
  property p_ans; psel_i && penable_i && !pready_o |=> pready_o; endproperty
  a_ans: assert property (p_ans) else $error("access not answered");
  property p_err; pslverr_o |-> pready_o && prdata_o == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error response");
  property p_upper; pready_o |-> prdata_o[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  c_smp: cover property (ana_sample_o);
  c_irq: cover property (conversion_irq_o);
  c_err: cover property (pslverr_o);
endmodule // adc_sequencer_regs_checker
bind adc_sequencer_regs adc_sequencer_regs_checker u_chk (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .global_irq_enable_i(global_irq_enable_i),
  .ana_enable_o(ana_enable_o), .ana_sample_o(ana_sample_o),
  .ana_reference_o(ana_reference_o), .ana_channel_o(ana_channel_o),
  .conversion_irq_o(conversion_irq_o));

// ### verification/adc_front_model.sv
`timescale 1ns/1ps
module adc_front_model (
  input wire logic mclk_i,
  input wire logic enable_i,
  input wire logic [4:0] channel_i,
  input wire logic [10:0] level_i,
  output logic [10:0] value_o
);
  logic [10:0] idle_r = 11'h2aa;
  // Powered down it shows a changing pattern, so a stale level never passes
  always_ff @(posedge mclk_i) begin
    idle_r <= ~idle_r;
  end
  // Ground channel reads zero, every other channel the applied level
  assign value_o = !enable_i ? idle_r : (channel_i == 5'h1f) ? 11'h000 : level_i;
endmodule // adc_front_model

// ### verification/test_adc_sequencer_regs.sv
`timescale 1ns/1ps
module test_adc_sequencer_regs;
  localparam logic [11:0] LO = 12'h1e0;
  localparam logic [11:0] HI = 12'h1e4;
  localparam logic [11:0] CTL = 12'h1e8;
  localparam logic [11:0] MUX = 12'h1ec;
  localparam logic [11:0] CTB = 12'h1f0;
  logic mclk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic pready_o, pslverr_o, ana_enable_o, ana_sample_o, conversion_irq_o;
  logic [7:1] trigger_sources_i = 7'h00;
  logic irq_vector_ack_i = 0, global_irq_enable_i = 0;
  logic [10:0] ana_value_i, level = 11'h000;
  logic [1:0] ana_reference_o;
  logic [4:0] ana_channel_o;
  int mismatches = 0, total_checks = 0, cycles = 0, n1, n2, k;
  always #20 mclk_i = ~mclk_i;
  adc_sequencer_regs dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .trigger_sources_i(trigger_sources_i), .irq_vector_ack_i(irq_vector_ack_i),
    .global_irq_enable_i(global_irq_enable_i), .ana_value_i(ana_value_i),
    .ana_enable_o(ana_enable_o), .ana_sample_o(ana_sample_o),
    .ana_reference_o(ana_reference_o), .ana_channel_o(ana_channel_o),
    .conversion_irq_o(conversion_irq_o));
  adc_front_model afe (.mclk_i(mclk_i), .enable_i(ana_enable_o), .channel_i(ana_channel_o),
    .level_i(level), .value_o(ana_value_i));
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; returns the error bit above the read byte
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [8:0] r);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge mclk_i);
    penable_i <= 1;
    // Wait as long as the slave needs; only the bench timeout ends a hang
    do begin
      @(posedge mclk_i);
    end while (pready_o !== 1'b1);
    r = {pslverr_o, prdata_o[7:0]};
    psel_i <= 0;
    penable_i <= 0;
    // One idle edge, so the next setup never reassigns psel in this step
    @(posedge mclk_i);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    logic [8:0] r;
    apb(1'b1, a, d, r);
  endtask
  task rd(input logic [11:0] a, input logic [8:0] e);
    logic [8:0] r;
    apb(1'b0, a, 8'h00, r);
    chk(r, e);
  endtask
  // Run one single conversion, time it to the interrupt, then clear the flag
  task conv(input logic [7:0] c, input logic ack, output int n);
    wr(CTL, c);
    n = 0;
    while (conversion_irq_o !== 1'b1) begin
      @(posedge mclk_i);
      n++;
    end
    if (ack) begin
      irq_vector_ack_i <= 1;
      @(posedge mclk_i);
      irq_vector_ack_i <= 0;
    end else wr(CTL, c & 8'hbf | 8'h10);
    repeat (3) @(posedge mclk_i);
    chk(conversion_irq_o, 0);
  endtask
  task samples(input int c, output int s);
    s = 0;
    repeat (c) begin
      @(posedge mclk_i);
      if (ana_sample_o === 1'b1) s++;
    end
  endtask
  task t_reset;
    rd(CTL, 9'h000);
    wr(CTL, 8'h2f);
    rd(CTL, 9'h02f);
    wr(CTL, 8'h00);
    rd(12'h100, 9'h100);
  endtask
  task t_conv;
    wr(MUX, 8'h00);
    level <= 11'd1100;
    conv(8'hcb, 1'b0, n1);
    conv(8'hcb, 1'b1, n2);
    chk(n1 - n2 > 88 && n1 - n2 < 104, 1);
    rd(LO, 9'h0ff);
    rd(HI, 9'h003);
    wr(MUX, 8'h20);
    rd(LO, 9'h0c0);
    rd(HI, 9'h0ff);
    rd(CTL, 9'h08b);
    wr(MUX, 8'hf0);
    level <= 11'h400;
    conv(8'hc8, 1'b0, n1);
    chk(ana_channel_o, 5'h10);
    chk(ana_reference_o, 2'h3);
    rd(LO, 9'h000);
    level <= 11'h3ff;
    conv(8'hc9, 1'b0, n2);
    chk(n1 - n2 > -2 && n1 - n2 < 2, 1);
    rd(HI, 9'h080);
    conv(8'hc9, 1'b0, n2);
    rd(LO, 9'h0c0);
    rd(HI, 9'h07f);
  endtask
  task t_abort;
    wr(MUX, 8'h05);
    wr(CTL, 8'hcf);
    wr(MUX, 8'h06);
    chk(ana_channel_o, 5'h05);
    wr(CTL, 8'h8f);
    rd(CTL, 9'h0cf);
    wr(CTL, 8'h0f);
    @(posedge mclk_i);
    chk(ana_enable_o, 0);
    rd(CTL, 9'h00f);
  endtask
  task t_auto;
    wr(CTB, 8'h02);
    wr(CTL, 8'hab);
    trigger_sources_i[2] <= 1;
    n1 = 0;
    while (conversion_irq_o !== 1'b1 && n1 < 2000) begin
      @(posedge mclk_i);
      n1++;
    end
    chk(conversion_irq_o, 1);
    wr(CTB, 8'h00);
    samples(100, k);
    chk(k, 0);
    wr(CTL, 8'hfb);
    samples(400, k);
    chk(k >= 3, 1);
    wr(CTL, 8'h00);
    trigger_sources_i[2] <= 0;
  endtask
  // Cut a hang short
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      final_report;
    end
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1;
    global_irq_enable_i <= 1;
    @(posedge mclk_i);
    t_reset;
    t_conv;
    t_abort;
    t_auto;
    final_report;
  end
endmodule // test_adc_sequencer_regs
